// *** bench/afe_link_asserts.sv ***
// checker for the shared converter link: selects, data release, clock sharing, start pacing
// assumes the bench wires the link interface signals straight in, beside the two ends
`timescale 1ns/1ps
module afe_link_asserts import afe_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sclk,
	input wire logic din,
	input wire logic start,
	input wire logic [NDEV-1:0] cs_n,
	input wire logic [NDEV-1:0] dout_oe,
	input wire logic [NDEV-1:0] clk_oe,
	input wire logic [NDEV-1:0] ready_n
);
	// ****
	// start pulse length, counted in pclk cycles
	// ****
	logic [7:0] hi_r;
	logic [7:0] hi_nxt;
	always_comb hi_nxt = start ? hi_r + 8'h01 : 8'h00;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) hi_r <= 8'h00;
		else hi_r <= hi_nxt;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****
	// properties
	// ****
	// four cycles covers the three-cycle synchroniser lag of the release
	property p_rel0; cs_n[0] [*4] |-> !dout_oe[0]; endproperty
	a_rel0: assert property (p_rel0) else $error("device 0 drives data while deselected");
	property p_rel1; cs_n[1] [*4] |-> !dout_oe[1]; endproperty
	a_rel1: assert property (p_rel1) else $error("device 1 drives data while deselected");
	property p_drv0; $fell(cs_n[0]) |-> ##[2:4] dout_oe[0]; endproperty
	a_drv0: assert property (p_drv0) else $error("device 0 never drives after select");
	property p_one_cs; $onehot0(~cs_n); endproperty
	a_one_cs: assert property (p_one_cs) else $error("two devices selected at once");
	property p_one_clk; $onehot0(clk_oe); endproperty
	a_one_clk: assert property (p_one_clk) else $error("two clock drivers");
	property p_idle; &cs_n |-> !sclk; endproperty
	a_idle: assert property (p_idle) else $error("serial clock moves with no select");
	property p_din_hold; sclk && $past(sclk) |-> $stable(din); endproperty
	a_din_hold: assert property (p_din_hold) else $error("data changes while serial clock high");
	property p_start_len; $fell(start) |-> hi_r >= START_CYC; endproperty
	a_start_len: assert property (p_start_len) else $error("start pulse too short");
	property p_rdy_clr; $rose(start) |-> ##[1:5] (&ready_n); endproperty
	a_rdy_clr: assert property (p_rdy_clr) else $error("ready not cleared by start");
	c_frame0: cover property ($fell(cs_n[0]));
	c_frame1: cover property ($fell(cs_n[1]));
	c_ready: cover property ($fell(ready_n[0]) && !start);
endmodule : afe_link_asserts

// *** bench/tb_top.sv ***
// testbench: one host and two converters on the shared link, host ordered over APB
// assumes converter 0 owns the clock pin and converter 1 follows it
`timescale 1ns/1ps
module tb_top import afe_pkg::*; ;
	typedef struct packed {
		logic dev;
		logic [6:0] addr;
		logic [7:0] data;
		logic [2:0] pick;
		logic [3:0] exp;
	} row_s;
	// each row: one register write, then one output and the value it must show afterwards
	localparam row_s ROWS [15] = '{
		'{1'b0, ADDR_ELECTRODE_CHECK_CONFIG_REG, 8'he8, 3'h1, 4'h7}, '{1'b0, ADDR_ELECTRODE_CHECK_CONFIG_REG, 8'he8, 3'h0, 4'h2}, '{1'b0, 7'h06, 8'hff, 3'h1, 4'h7},
		'{1'b0, ADDR_SENS, 8'h0f, 3'h3, 4'hf}, '{1'b0, ADDR_SENS, 8'h0f, 3'h4, 4'h5}, '{1'b0, ADDR_SENS, 8'h1f, 3'h4, 4'h6},
		'{1'b0, ADDR_SENS, 8'h1f, 3'h5, 4'h9}, '{1'b0, ADDR_ELECTRODE_CHECK_CONFIG_REG, 8'hea, 3'h4, 4'h0}, '{1'b0, ADDR_ELECTRODE_CHECK_CONFIG_REG, 8'hea, 3'h3, 4'hf},
		'{1'b0, ADDR_CFG2, 8'h60, 3'h2, 4'h0}, '{1'b0, ADDR_CFG2, 8'h20, 3'h2, 4'h1}, '{1'b1, ADDR_CH1, 8'h06, 3'h6, 4'h1},
		'{1'b1, ADDR_CH2, 8'h07, 3'h7, 4'h2}, '{1'b1, ADDR_CH1, 8'h07, 3'h7, 4'h3}, '{1'b1, ADDR_CH1, 8'h07, 3'h6, 4'h0}};
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [1:0] sel_pin = 2'b01;
	logic [3:0] hit = 4'h6;
	logic drive_hit = 1'b1;
	logic amp_on = 1'b0;
	logic check_req = 1'b0;
	logic [3:0] sense [2];
	logic [3:0] src [2];
	logic [3:0] sink [2];
	logic [1:0] lvl [2];
	logic [2:0] thr [2];
	logic cmp_en [2];
	logic [1:0] rp [2];
	logic [1:0] rn [2];
	logic dce [2];
	logic [31:0] rd;
	logic err;
	logic prev;
	int n_fail = 0;
	int checked = 0;
	int d0, d1, d2, d3, e0, e1;
	afe_link_if lk ();
	always #25 pclk = ~pclk;
	for (genvar g = 0; g < NDEV; g++) begin : g_dev
		afe_device #(.DEV_ID(g)) afe_device_i (.pclk(pclk), .presetn(presetn), .lk(lk),
			.clock_source_select_pin(sel_pin[g]), .comp_hit(hit), .drive_comp_hit(drive_hit),
			.drive_amp_on(amp_on), .power_up_check_req(check_req), .sense_en(sense[g]), .exc_src_en(src[g]),
			.exc_sink_en(sink[g]), .excitation_current_level(lvl[g]), .comparator_threshold(thr[g]),
			.comparator_enable(cmp_en[g]), .route_p_drive(rp[g]), .route_n_drive(rn[g]), .drive_check_en(dce[g]));
	end
	afe_host afe_host_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lk(lk));
	afe_link_asserts afe_link_asserts_i (.pclk(pclk), .presetn(presetn), .sclk(lk.sclk), .din(lk.din),
		.start(lk.start), .cs_n(lk.cs_n), .dout_oe(lk.dout_oe), .clk_oe(lk.clk_oe), .ready_n(lk.ready_n));
	// ****
	// tasks
	// ****
	function automatic logic [3:0] observed(input logic d, input logic [2:0] p);
		case (p)
			3'h0: return {2'h0, lvl[d]};
			3'h1: return {1'b0, thr[d]};
			3'h2: return {3'h0, cmp_en[d]};
			3'h3: return sense[d];
			3'h4: return src[d];
			3'h5: return sink[d];
			3'h6: return {2'h0, rp[d]};
			default: return {2'h0, rn[d]};
		endcase
	endfunction : observed
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	// the leading edge keeps psel low for a cycle between transfers
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic xfer(input logic dev, input logic w, input logic [6:0] a, input logic [7:0] d);
		apb(1'b1, APB_CTRL, {15'h0000, dev, w, a, d});
		do apb(1'b0, APB_STATUS, 32'h0000_0000); while (rd[0] !== 1'b0);
	endtask : xfer
	task automatic readback(input logic [15:0] exp);
		xfer(1'b0, 1'b0, ADDR_ELECTRODE_CHECK_CONFIG_REG, 8'h00);
		apb(1'b0, APB_RX, 32'h0000_0000);
		chk({16'h0000, rd[15:0]}, {16'h0000, exp}, "frame");
	endtask : readback
	task automatic run_start(output int t0, output int t1);
		t0 = -1;
		t1 = -1;
		apb(1'b1, APB_START, 32'h0000_0001);
		for (int c = 0; c < 15000 && (t0 < 0 || t1 < 0); c++) begin
			@(posedge pclk);
			if (c > 8 && t0 < 0 && lk.ready_n[0] === 1'b0) t0 = c;
			if (c > 8 && t1 < 0 && lk.ready_n[1] === 1'b0) t1 = c;
		end
	endtask : run_start
	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	// ****
	// sequence
	// ****
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ROWS[i]) begin
			xfer(ROWS[i].dev, 1'b1, ROWS[i].addr, ROWS[i].data);
			chk(32'(observed(ROWS[i].dev, ROWS[i].pick)), 32'(ROWS[i].exp), "register effect");
		end
		chk(32'(lk.clk_oe), 32'h0000_0001, "clock driver");
		chk(32'({src[1], sink[1]}), 32'h0000_0000, "rerouted channels unexcited");
		readback(16'hea16);
		hit <= 4'h9;
		drive_hit <= 1'b0;
		repeat (400) @(posedge pclk);
		readback(16'hea09);
		xfer(1'b0, 1'b1, ADDR_CFG2, 8'h60);
		repeat (400) @(posedge pclk);
		readback(16'hea00);
		xfer(1'b0, 1'b1, ADDR_CFG2, 8'h20);
		for (int i = 0; i < 4; i++) begin
			{check_req, amp_on} <= 2'(i);
			repeat (2) @(posedge pclk);
			chk(32'(dce[0]), 32'(i == 2), "drive check gate");
		end
		// a start pulse lands at any phase of the modulator tick, so one tick of slack
		run_start(d0, d1);
		chk(32'(d0 >= 11070 && d0 <= 11400), 32'h0000_0001, "settle time");
		chk(32'((d0 > d1 ? d0 - d1 : d1 - d0) <= 164), 32'h0000_0001, "settle spread");
		xfer(1'b0, 1'b1, ADDR_ELECTRODE_CHECK_CONFIG_REG, 8'he9);
		e0 = -1;
		e1 = -1;
		prev = src[0][0];
		for (int c = 0; c < 12000 && e1 < 0; c++) begin
			@(posedge pclk);
			if (src[0][0] !== prev && e0 >= 0) e1 = c;
			if (src[0][0] !== prev && e0 < 0) e0 = c;
			prev = src[0][0];
		end
		chk(32'(e1 - e0), 32'h0000_1380, "ac swap interval");
		run_start(d2, d3);
		chk(32'((d0 > d2 ? d0 - d2 : d2 - d0) <= 164), 32'h0000_0001, "repeat settle");
		apb(1'b1, APB_CTRL, {15'h0000, 1'b1, 1'b1, ADDR_ELECTRODE_CHECK_CONFIG_REG, 8'hff});
		xfer(1'b1, 1'b1, ADDR_SENS, 8'h3f);
		chk(32'(thr[1]), 32'h0000_0007, "first order");
		chk(32'(sense[1]), 32'h0000_0000, "order while busy");
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk(32'(err), 32'h0000_0001, "unmapped address");
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		chk(32'(cmp_en[0]), 32'h0000_0000, "comparators after reset");
		chk(32'(thr[0]), 32'h0000_0000, "threshold after reset");
		chk(32'(lk.dout_oe), 32'h0000_0000, "data released after reset");
		apb(1'b0, APB_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0006, "status after reset");
		tally_and_finish();
	end
	initial begin
		#4_000_000;
		n_fail++;
		$display("CHECK FAILED at %0t: run timed out", $time);
		tally_and_finish();
	end
endmodule : tb_top

// *** hw/afe_device.sv ***
// converter end: serial register access, clock sharing, start alignment, electrode-off control
// assumes the host keeps its own link rules; analog comparators arrive unsynchronised
`timescale 1ns/1ps
module afe_device import afe_pkg::*; #(
	parameter int DEV_ID = 0
) (
	input wire logic pclk,
	input wire logic presetn,
	afe_link_if.dev lk,
	input wire logic clock_source_select_pin,
	input wire logic [2*NCH-1:0] comp_hit,
	input wire logic drive_comp_hit,
	input wire logic drive_amp_on,
	input wire logic power_up_check_req,
	output logic [2*NCH-1:0] sense_en,
	output logic [2*NCH-1:0] exc_src_en,
	output logic [2*NCH-1:0] exc_sink_en,
	output logic [1:0] excitation_current_level,
	output logic [2:0] comparator_threshold,
	output logic comparator_enable,
	output logic [NCH-1:0] route_p_drive,
	output logic [NCH-1:0] route_n_drive,
	output logic drive_check_en
);

	// ************************************************************
	// input synchronisers
	// ************************************************************
	logic [SYNC_W-1:0] sync_q;
	logic sclk_s, din_s, start_s, cs_s, clkin_s, sel_s, dcomp_s;
	logic [2*NCH-1:0] comp_s;

	afe_sync2 #(.W(SYNC_W), .INIT(11'h008)) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d({comp_hit, drive_comp_hit, clock_source_select_pin, lk.clk_line, lk.cs_n[DEV_ID],
			lk.start, lk.din, lk.sclk}),
		.q(sync_q)
	);

	assign {comp_s, dcomp_s, sel_s, clkin_s, cs_s, start_s, din_s, sclk_s} = sync_q;

	// ************************************************************
	// state
	// ************************************************************
	logic [7:0] cfg2_r, cfg2_nxt, electrode_check_config_reg_r, electrode_check_config_reg_nxt, sens_r, sens_nxt, stat_r, stat_nxt;
	logic [7:0] ch_r [NCH];
	logic [7:0] ch_nxt [NCH];
	logic [FRAME_W-1:0] sh_in_r, sh_in_nxt, sh_out_r, sh_out_nxt, frame;
	logic [3:0] bit_r, bit_nxt;
	logic [3:0] prev_r, prev_nxt;
	logic [7:0] div_r, div_nxt;
	logic clk_out_r, clk_out_nxt;
	logic run_r, run_nxt, ready_n_r, ready_n_nxt, oe_r, oe_nxt;
	logic [13:0] wait_r, wait_nxt, period;
	logic [1:0] ac_r, ac_nxt;
	logic tick, sclk_rise, sclk_fall, cs_fall, start_rise;

	always_comb begin
		cfg2_nxt = cfg2_r;
		electrode_check_config_reg_nxt = electrode_check_config_reg_r;
		sens_nxt = sens_r;
		ch_nxt = ch_r;
		stat_nxt = stat_r;
		sh_in_nxt = sh_in_r;
		sh_out_nxt = sh_out_r;
		bit_nxt = bit_r;
		run_nxt = run_r;
		wait_nxt = wait_r;
		ready_n_nxt = ready_n_r;
		ac_nxt = ac_r;
		prev_nxt = {sclk_s, cs_s, start_s, clkin_s};
		sclk_rise = sclk_s & ~prev_r[3];
		sclk_fall = ~sclk_s & prev_r[3];
		cs_fall = ~cs_s & prev_r[2];
		start_rise = start_s & ~prev_r[1];
		frame = {sh_in_r[FRAME_W-2:0], din_s};
		period = DR_BASE_MODS << cfg2_r[CFG2_DR_LSB +: 3];
		oe_nxt = ~cs_s;

		// modulator clock: own divider when strapped as source, else rising edges of the shared pin
		div_nxt = (div_r == MOD_DIV - 8'h01) ? 8'h00 : div_r + 8'h01;
		clk_out_nxt = div_r < MOD_HALF;
		tick = sel_s ? (div_r == MOD_DIV - 8'h01) : (clkin_s & ~prev_r[0]);

		// ************************************************************
		// serial frame
		// ************************************************************
		if (cs_fall) begin
			sh_out_nxt = {electrode_check_config_reg_r, stat_r};
			bit_nxt = 4'h0;
			ready_n_nxt = 1'b1;
		end else if (!cs_s) begin
			if (sclk_rise) begin
				sh_in_nxt = frame;
				bit_nxt = bit_r + 4'h1;
				if (bit_r == 4'hf && frame[FRAME_W-1]) begin
					unique case (frame[14:8])
						ADDR_CFG2: cfg2_nxt = frame[7:0];
						ADDR_ELECTRODE_CHECK_CONFIG_REG: electrode_check_config_reg_nxt = frame[7:0];
						ADDR_SENS: sens_nxt = frame[7:0];
						ADDR_CH1: ch_nxt[0] = frame[7:0];
						ADDR_CH2: ch_nxt[1] = frame[7:0];
						default: ;
					endcase
				end
			end
			if (sclk_fall) begin
				sh_out_nxt = {sh_out_r[FRAME_W-2:0], 1'b0};
			end
		end

		// ************************************************************
		// start and data pacing, counted in modulator ticks only
		// ************************************************************
		// the host only pulses start for about one modulator period, far shorter than the settle wait,
		// so the fall of the pin must not stop the run; only a new rise realigns the pacing
		if (start_rise) begin
			run_nxt = 1'b1;
			wait_nxt = (period << 2) + SETTLE_EXTRA;
			ready_n_nxt = 1'b1;
			ac_nxt = 2'h0;
		end else if (tick && run_r) begin
			if (wait_r == 14'h0000) begin
				ready_n_nxt = 1'b0;
				wait_nxt = period - 14'h0001;
				ac_nxt = ac_r + 2'h1;
			end else begin
				wait_nxt = wait_r - 14'h0001;
			end
		end

		// ************************************************************
		// comparator capture; sensing disabled sides read as zero
		// ************************************************************
		if (tick) begin
			if (cfg2_r[CFG2_COMP_PD_BIT]) begin
				stat_nxt = STAT_RST;
			end else begin
				stat_nxt = STAT_RST;
				stat_nxt[2*NCH-1:0] = comp_s & sens_r[2*NCH-1:0];
				stat_nxt[STAT_DRIVE_BIT] = dcomp_s;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg2_r <= CFG2_RST;
			electrode_check_config_reg_r <= ELECTRODE_CHECK_CONFIG_REG_RST;
			sens_r <= SENS_RST;
			stat_r <= STAT_RST;
			for (int i = 0; i < NCH; i++) begin
				ch_r[i] <= CH_RST;
			end
			sh_in_r <= 16'h0000;
			sh_out_r <= 16'hffff;
			bit_r <= 4'h0;
			prev_r <= 4'h4;
			div_r <= 8'h00;
			clk_out_r <= 1'b0;
			run_r <= 1'b0;
			wait_r <= 14'h0000;
			ready_n_r <= 1'b1;
			ac_r <= 2'h0;
			oe_r <= 1'b0;
		end else begin
			cfg2_r <= cfg2_nxt;
			electrode_check_config_reg_r <= electrode_check_config_reg_nxt;
			sens_r <= sens_nxt;
			stat_r <= stat_nxt;
			ch_r <= ch_nxt;
			sh_in_r <= sh_in_nxt;
			sh_out_r <= sh_out_nxt;
			bit_r <= bit_nxt;
			prev_r <= prev_nxt;
			div_r <= div_nxt;
			clk_out_r <= clk_out_nxt;
			run_r <= run_nxt;
			wait_r <= wait_nxt;
			ready_n_r <= ready_n_nxt;
			ac_r <= ac_nxt;
			oe_r <= oe_nxt;
		end
	end

	// ************************************************************
	// pins and analog controls
	// ************************************************************
	// release lags the select by the synchroniser, three pclk cycles at most
	assign lk.dout_o[DEV_ID] = sh_out_r[FRAME_W-1];
	assign lk.dout_oe[DEV_ID] = oe_r;
	assign lk.clk_o[DEV_ID] = clk_out_r;
	assign lk.clk_oe[DEV_ID] = sel_s & cfg2_r[CFG2_CLK_OUT_BIT];
	assign lk.ready_n[DEV_ID] = ready_n_r;

	assign sense_en = sens_r[2*NCH-1:0];
	assign excitation_current_level = electrode_check_config_reg_r[ELECTRODE_CHECK_CONFIG_REG_ILEV_LSB +: 2];
	assign comparator_threshold = electrode_check_config_reg_r[ELECTRODE_CHECK_CONFIG_REG_TH_LSB +: 3];
	assign comparator_enable = ~cfg2_r[CFG2_COMP_PD_BIT];
	assign drive_check_en = power_up_check_req & ~drive_amp_on;

	generate
		for (genvar c = 0; c < NCH; c++) begin : g_ch
			logic exc_p, exc_n, swap;
			// sensing stays live when excitation is switched off
			assign exc_p = sens_r[2*c] & ~electrode_check_config_reg_r[ELECTRODE_CHECK_CONFIG_REG_EXC_OFF_BIT];
			assign exc_n = sens_r[2*c+1] & ~electrode_check_config_reg_r[ELECTRODE_CHECK_CONFIG_REG_EXC_OFF_BIT];
			assign swap = sens_r[SENS_SWAP_LSB+c] ^ (electrode_check_config_reg_r[ELECTRODE_CHECK_CONFIG_REG_AC_BIT] & ac_r[1]);
			assign exc_src_en[2*c] = exc_p & ~swap;
			assign exc_sink_en[2*c] = exc_p & swap;
			assign exc_src_en[2*c+1] = exc_n & swap;
			assign exc_sink_en[2*c+1] = exc_n & ~swap;
			assign route_p_drive[c] = ch_r[c][3:0] == ROUTE_DRIVE_P;
			assign route_n_drive[c] = ch_r[c][3:0] == ROUTE_DRIVE_N;
		end
	endgenerate

endmodule : afe_device

// *** hw/afe_host.sv ***
// host end: APB slave that runs one 16-bit serial frame per order and paces the start pin
// assumes converters sample its serial clock with their own pclk
`timescale 1ns/1ps
module afe_host import afe_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	afe_link_if.host lk
);
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_LEAD = 3'b001,
		S_HIGH = 3'b010,
		S_LOW = 3'b011,
		S_TRAIL = 3'b100
	} hstate_e;

	// ************************************************************
	// sampled link inputs
	// ************************************************************
	logic [NDEV:0] in_s;

	afe_sync2 #(.W(NDEV + 1), .INIT('1)) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d({lk.ready_n, lk.dout_line}),
		.q(in_s)
	);

	// ************************************************************
	// state
	// ************************************************************
	hstate_e st_r, st_nxt;
	logic [FRAME_W-1:0] tx_r, tx_nxt, rx_r, rx_nxt;
	logic sel_r, sel_nxt, sclk_r, sclk_nxt, din_r, din_nxt;
	logic [NDEV-1:0] cs_n_r, cs_n_nxt;
	logic [3:0] tim_r, tim_nxt, bit_r, bit_nxt;
	logic [7:0] start_r, start_nxt;
	logic wr, mapped;

	always_comb begin
		st_nxt = st_r;
		tx_nxt = tx_r;
		rx_nxt = rx_r;
		sel_nxt = sel_r;
		sclk_nxt = sclk_r;
		din_nxt = din_r;
		cs_n_nxt = cs_n_r;
		bit_nxt = bit_r;
		tim_nxt = (tim_r == 4'h0) ? SCLK_HALF - 4'h1 : tim_r - 4'h1;
		start_nxt = (start_r == 8'h00) ? 8'h00 : start_r - 8'h01;
		wr = psel & penable & pwrite;
		mapped = paddr == APB_CTRL || paddr == APB_STATUS || paddr == APB_RX || paddr == APB_START;
		if (wr && paddr == APB_START && pwdata[0]) begin
			start_nxt = START_CYC;
		end
		unique case (st_r)
			S_IDLE: begin
				// an order while a frame runs is dropped; software polls busy first
				if (wr && paddr == APB_CTRL) begin
					tx_nxt = pwdata[FRAME_W-1:0];
					sel_nxt = pwdata[FRAME_W];
					cs_n_nxt = ~(NDEV'(1) << pwdata[FRAME_W]);
					din_nxt = pwdata[FRAME_W-1];
					bit_nxt = 4'h0;
					tim_nxt = SCLK_HALF - 4'h1;
					st_nxt = S_LEAD;
				end
			end
			S_LEAD, S_LOW: begin
				if (tim_r == 4'h0) begin
					sclk_nxt = 1'b1;
					st_nxt = S_HIGH;
				end
			end
			S_HIGH: begin
				if (tim_r == 4'h0) begin
					rx_nxt = {rx_r[FRAME_W-2:0], in_s[0]};
					sclk_nxt = 1'b0;
					bit_nxt = bit_r + 4'h1;
					tx_nxt = {tx_r[FRAME_W-2:0], 1'b0};
					din_nxt = tx_r[FRAME_W-2];
					st_nxt = (bit_r == 4'hf) ? S_TRAIL : S_LOW;
				end
			end
			S_TRAIL: begin
				if (tim_r == 4'h0) begin
					cs_n_nxt = '1;
					st_nxt = S_IDLE;
				end
			end
			default: st_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= S_IDLE;
			tx_r <= 16'h0000;
			rx_r <= 16'h0000;
			sel_r <= 1'b0;
			sclk_r <= 1'b0;
			din_r <= 1'b0;
			cs_n_r <= '1;
			tim_r <= 4'h0;
			bit_r <= 4'h0;
			start_r <= 8'h00;
		end else begin
			st_r <= st_nxt;
			tx_r <= tx_nxt;
			rx_r <= rx_nxt;
			sel_r <= sel_nxt;
			sclk_r <= sclk_nxt;
			din_r <= din_nxt;
			cs_n_r <= cs_n_nxt;
			tim_r <= tim_nxt;
			bit_r <= bit_nxt;
			start_r <= start_nxt;
		end
	end

	// ************************************************************
	// APB answers and pins
	// ************************************************************
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	always_comb begin
		prdata = 32'h0000_0000;
		unique case (paddr)
			APB_CTRL: prdata = {15'h0000, sel_r, tx_r};
			APB_STATUS: prdata = {29'h0000_0000, in_s[NDEV:1], st_r != S_IDLE};
			APB_RX: prdata = {16'h0000, rx_r};
			APB_START: prdata = {31'h0000_0000, start_r != 8'h00};
			default: prdata = 32'h0000_0000;
		endcase
	end

	assign lk.sclk = sclk_r;
	assign lk.din = din_r;
	assign lk.cs_n = cs_n_r;
	assign lk.start = start_r != 8'h00;

endmodule : afe_host

// *** hw/afe_link_if.sv ***
// shared serial link between one host and NDEV converters, plus the shared clock pin
// resolves the shared wires from the drivers' enables; undriven data line floats high
`timescale 1ns/1ps
interface afe_link_if;
	import afe_pkg::*;
	logic sclk;
	logic din;
	logic start;
	logic [NDEV-1:0] cs_n;
	wire [NDEV-1:0] dout_o;
	wire [NDEV-1:0] dout_oe;
	wire [NDEV-1:0] clk_o;
	wire [NDEV-1:0] clk_oe;
	wire [NDEV-1:0] ready_n;
	logic dout_line;
	logic clk_line;

	assign dout_line = (|dout_oe) ? |(dout_o & dout_oe) : 1'b1;
	assign clk_line = |(clk_o & clk_oe);

	modport host (output sclk, output din, output start, output cs_n, input dout_line, input ready_n);
	modport dev (input sclk, input din, input start, input cs_n, input clk_line,
		output dout_o, output dout_oe, output clk_o, output clk_oe, output ready_n);
endinterface : afe_link_if

// *** hw/afe_pkg.sv ***
// constants shared by the converter end, the host end and their link
// assumes one 20 MHz pclk on both ends; all link pins are sampled, never used as clocks
package afe_pkg;

	// ************************************************************
	// link shape
	// ************************************************************
	localparam int NDEV = 2;
	localparam int NCH = 2;
	localparam int FRAME_W = 16;
	localparam int SYNC_W = 11;

	// ************************************************************
	// converter register addresses, frame bit 15 = write, 14:8 = address
	// ************************************************************
	localparam logic [6:0] ADDR_CFG2 = 7'h01;
	localparam logic [6:0] ADDR_ELECTRODE_CHECK_CONFIG_REG = 7'h02;
	localparam logic [6:0] ADDR_SENS = 7'h03;
	localparam logic [6:0] ADDR_CH1 = 7'h04;
	localparam logic [6:0] ADDR_CH2 = 7'h05;

	// ************************************************************
	// field positions and reset values
	// ************************************************************
	localparam int CFG2_DR_LSB = 0;
	localparam int CFG2_CLK_OUT_BIT = 5;
	localparam int CFG2_COMP_PD_BIT = 6;
	localparam int ELECTRODE_CHECK_CONFIG_REG_AC_BIT = 0;
	localparam int ELECTRODE_CHECK_CONFIG_REG_EXC_OFF_BIT = 1;
	localparam int ELECTRODE_CHECK_CONFIG_REG_ILEV_LSB = 2;
	localparam int ELECTRODE_CHECK_CONFIG_REG_TH_LSB = 5;
	localparam int SENS_SWAP_LSB = 4;
	localparam int STAT_DRIVE_BIT = 4;
	localparam logic [7:0] CFG2_RST = 8'h40;
	localparam logic [7:0] ELECTRODE_CHECK_CONFIG_REG_RST = 8'h00;
	localparam logic [7:0] SENS_RST = 8'h00;
	localparam logic [7:0] CH_RST = 8'h00;
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [3:0] ROUTE_DRIVE_P = 4'h6;
	localparam logic [3:0] ROUTE_DRIVE_N = 4'h7;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int T_PCLK_PS = 50000;
	localparam int T_MOD_PS = 7812500;
	localparam logic [7:0] MOD_DIV = 8'(T_MOD_PS / T_PCLK_PS);
	localparam logic [7:0] MOD_HALF = 8'(T_MOD_PS / T_PCLK_PS / 2);
	localparam logic [7:0] START_CYC = 8'((T_MOD_PS + T_PCLK_PS - 1) / T_PCLK_PS);
	localparam logic [13:0] DR_BASE_MODS = 14'h0010;
	localparam logic [13:0] SETTLE_EXTRA = 14'h0008;
	localparam logic [3:0] SCLK_HALF = 4'h8;

	// ************************************************************
	// host APB map
	// ************************************************************
	localparam logic [7:0] APB_CTRL = 8'h00;
	localparam logic [7:0] APB_STATUS = 8'h04;
	localparam logic [7:0] APB_RX = 8'h08;
	localparam logic [7:0] APB_START = 8'h0c;

endpackage : afe_pkg

// *** hw/afe_sync2.sv ***
// two-flop synchroniser for a bundle of independent levels
// only the second stage may be read by the caller
`timescale 1ns/1ps
module afe_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= INIT;
			q <= INIT;
		end else begin
			s1_r <= d;
			q <= s1_r;
		end
	end
endmodule : afe_sync2
